// *** hdl/ufc_cfg.svh ***
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UFC_OFF_FIFO_CTL    8'h08
`define UFC_OFF_IRQ_STAT    8'h20
`define UFC_OFF_IRQ_CLR     8'h24
`define UFC_OFF_IRQ_EN      8'h28

// ----------------------------------------------------------------------------
// Control register layout
// ----------------------------------------------------------------------------
`define UFC_FCR_RESET       32'h00000101
`define UFC_FCR_RSVD_MASK   32'hfff0fe09
`define UFC_BIT_RX_CLR      1
`define UFC_BIT_TX_CLR      2
`define UFC_RX_THR_LSB      4
`define UFC_RX_THR_MSB      7
`define UFC_BIT_RX_OFF      8
`define UFC_RTS_THR_LSB     16
`define UFC_RTS_THR_MSB     19
`define UFC_RX_OFF_RESET    1'h1
`define UFC_CODE_RESET      4'h0

// ----------------------------------------------------------------------------
// Threshold codes and byte counts
// ----------------------------------------------------------------------------
`define UFC_CODE_1B         4'h0
`define UFC_CODE_4B         4'h1
`define UFC_CODE_8B         4'h2
`define UFC_CODE_14B        4'h3
`define UFC_LEVEL_1         8'h01
`define UFC_LEVEL_4         8'h04
`define UFC_LEVEL_8         8'h08
`define UFC_LEVEL_14        8'h0e

// ----------------------------------------------------------------------------
// Path clear timing and interrupt layout
// ----------------------------------------------------------------------------
`define UFC_CLR_CYCLES      4'h3
`define UFC_CNT_W           4
`define UFC_IRQ_W           4
`define UFC_IRQ_RX_AVAIL    0
`define UFC_IRQ_RTS_DROP    1
`define UFC_IRQ_TX_DONE     2
`define UFC_IRQ_RX_DONE     3

`endif

// *** hdl/ufc_pkg.sv ***
`include "ufc_cfg.svh"

package ufc_pkg;

    typedef struct packed {
        logic [`UFC_CNT_W-1:0] cnt;
    } ufc_clr_state_t;

    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdata;
        logic [3:0]            rx_code;
        logic [3:0]            rts_code;
        logic                  rx_off;
        logic                  tx_clr;
        logic                  rx_clr;
        logic [`UFC_IRQ_W-1:0] stat;
        logic [`UFC_IRQ_W-1:0] en;
        logic                  irq;
        logic                  rx_int;
        logic                  rts;
    } ufc_state_t;

endpackage

// *** hdl/ufc_clr_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface ufc_clr_if;
    logic start;
    logic done;

    modport ctl  (output start, input  done);
    modport unit (input  start, output done);
endinterface

`default_nettype wire

// *** hdl/ufc_clr_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"

module ufc_clr_timer #(
    parameter logic [`UFC_CNT_W-1:0] CYCLES = `UFC_CLR_CYCLES
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control side
    ufc_clr_if.unit   clr
);

    ufc_pkg::ufc_clr_state_t q_r;
    ufc_pkg::ufc_clr_state_t q_nxt;

    // A new start reloads the count, so a second write stretches the clear.
    always_comb
    begin
        q_nxt = q_r;
        if (clr.start)
        begin
            q_nxt.cnt = CYCLES;
        end
        else if (q_r.cnt != '0)
        begin
            q_nxt.cnt = q_r.cnt - `UFC_CNT_W'(1);
        end
    end

    assign clr.done = (q_r.cnt == `UFC_CNT_W'(1)) && !clr.start;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

endmodule // ufc_clr_timer

`default_nettype wire

// *** hdl/ufc_level_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"

module ufc_level_decode #(
    parameter int OUT_W = 5
) (
    // Code in
    input  wire logic [3:0]       code_i,
    // Byte count out
    output logic      [OUT_W-1:0] level_o
);

    // Reserved codes fall back to one byte so a bad write never stalls flow.
    always_comb
    begin
        case (code_i)
            `UFC_CODE_4B:  level_o = OUT_W'(`UFC_LEVEL_4);
            `UFC_CODE_8B:  level_o = OUT_W'(`UFC_LEVEL_8);
            `UFC_CODE_14B: level_o = OUT_W'(`UFC_LEVEL_14);
            default:       level_o = OUT_W'(`UFC_LEVEL_1);
        endcase
    end

endmodule // ufc_level_decode

`default_nettype wire

// *** hdl/ufc_fifo_ctl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ufc_cfg.svh"

// Operation
// RULE1 - Flow threshold codes 0 to 3 mean 1, 4, 8 or 14 bytes and other codes are reserved.
// RULE2 - The flow threshold acts only for automatic RTS and exists only on flow-capable channels.
// RULE3 - With automatic RTS on, RTS drops once the receive byte count reaches the flow threshold.
// RULE4 - Setting receiver_off disables the receiver and clearing it enables the receiver.
// RULE5 - Software should set receiver_off before it enables multidrop normal mode.
// RULE6 - On FIFO channels the receive threshold codes 0 to 3 mean 1, 4, 8 or 14 bytes.
// RULE7 - A receive count equal to the threshold sets rx_avail_flag and interrupts if enabled.
// RULE8 - Single-buffer channels support only the one-byte receive threshold code.
// RULE9 - Writing one to tx_path_clear flushes and resets the transmit path, zero does nothing.
// RULE10 - Writing one to rx_path_clear flushes and resets the receive path, zero does nothing.
// RULE11 - Each path clear bit returns to zero by itself after no fewer than three cycles.
// RULE12 - Reserved control bits ignore writes and read back their reset values.
module ufc_fifo_ctl #(
    parameter int CNT_W    = 5,
    parameter bit HAS_FIFO = 1'b1,
    parameter bit HAS_FLOW = 1'b1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Receive and flow status from the channel
    input  wire logic [CNT_W-1:0] rx_count_i,
    input  wire logic             auto_rts_en_i,
    input  wire logic             rts_manual_i,
    // Controls to the channel
    output logic                  rts_o,
    output logic                  receiver_off_o,
    output logic                  tx_path_reset_o,
    output logic                  rx_path_reset_o,
    // Flags and interrupts
    output logic                  rx_avail_flag_o,
    output logic                  rx_avail_interrupt_o,
    output logic                  irq_o
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    ufc_pkg::ufc_state_t q_r;
    ufc_pkg::ufc_state_t q_nxt;

    logic                  bus_req;
    logic                  bus_wr;
    logic [7:0]            word_adr;
    logic                  hit_fcr;
    logic                  hit_stat;
    logic                  hit_clr;
    logic                  hit_en;
    logic                  wr_fcr;
    logic [CNT_W-1:0]      rx_level;
    logic [CNT_W-1:0]      rts_level;
    logic                  rx_at_level;
    logic                  rts_want;
    logic [`UFC_IRQ_W-1:0] irq_set;
    logic [`UFC_IRQ_W-1:0] irq_clr;
    logic [31:0]           fcr_view;

    ufc_clr_if tx_clr_if ();
    ufc_clr_if rx_clr_if ();

    // ------------------------------------------------------------------------
    // Threshold decoders
    // ------------------------------------------------------------------------
    // RULE6 receive threshold decode
    ufc_level_decode #(
        .OUT_W (CNT_W)
    ) u_rx_level (
        .code_i  (q_r.rx_code),
        .level_o (rx_level)
    );

    // RULE1 flow threshold decode
    ufc_level_decode #(
        .OUT_W (CNT_W)
    ) u_rts_level (
        .code_i  (q_r.rts_code),
        .level_o (rts_level)
    );

    // ------------------------------------------------------------------------
    // Path clear timers
    // ------------------------------------------------------------------------
    // RULE11 three cycle self clear
    ufc_clr_timer #(
        .CYCLES (`UFC_CLR_CYCLES)
    ) u_tx_clr (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .clr   (tx_clr_if.unit)
    );

    ufc_clr_timer #(
        .CYCLES (`UFC_CLR_CYCLES)
    ) u_rx_clr (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .clr   (rx_clr_if.unit)
    );

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // The ack flop blocks a second accept, so each request gives exactly one ack.
    assign bus_req  = wb_cyc_i && wb_stb_i && !q_r.ack;
    assign bus_wr   = bus_req && wb_we_i;
    assign word_adr = {wb_adr_i[7:2], 2'h0};
    assign hit_fcr  = (word_adr == `UFC_OFF_FIFO_CTL);
    assign hit_stat = (word_adr == `UFC_OFF_IRQ_STAT);
    assign hit_clr  = (word_adr == `UFC_OFF_IRQ_CLR);
    assign hit_en   = (word_adr == `UFC_OFF_IRQ_EN);
    assign wr_fcr   = bus_wr && hit_fcr;

    // RULE9 transmit clear on a written one
    assign tx_clr_if.start = wr_fcr && wb_sel_i[0] && wb_dat_i[`UFC_BIT_TX_CLR];

    // RULE10 receive clear on a written one
    assign rx_clr_if.start = wr_fcr && wb_sel_i[0] && wb_dat_i[`UFC_BIT_RX_CLR];

    // ------------------------------------------------------------------------
    // Control register read view
    // ------------------------------------------------------------------------
    always_comb
    begin
        // RULE12 reserved bits read reset value
        fcr_view = `UFC_FCR_RESET & `UFC_FCR_RSVD_MASK;
        fcr_view[`UFC_RTS_THR_MSB:`UFC_RTS_THR_LSB] = q_r.rts_code;
        fcr_view[`UFC_BIT_RX_OFF] = q_r.rx_off;
        fcr_view[`UFC_RX_THR_MSB:`UFC_RX_THR_LSB] = q_r.rx_code;
        fcr_view[`UFC_BIT_TX_CLR] = q_r.tx_clr;
        fcr_view[`UFC_BIT_RX_CLR] = q_r.rx_clr;
    end

    // ------------------------------------------------------------------------
    // Receive threshold and flow control
    // ------------------------------------------------------------------------
    // RULE7 count equals threshold
    assign rx_at_level = (rx_count_i == rx_level);

    always_comb
    begin
        // RULE3 drop RTS at the flow threshold
        // RULE2 threshold used only under automatic RTS
        if (HAS_FLOW && auto_rts_en_i)
        begin
            rts_want = (rx_count_i < rts_level);
        end
        else
        begin
            rts_want = rts_manual_i;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------------------
    always_comb
    begin
        irq_set = '0;
        irq_set[`UFC_IRQ_RX_AVAIL] = rx_at_level;
        irq_set[`UFC_IRQ_RTS_DROP] = q_r.rts && !rts_want;
        irq_set[`UFC_IRQ_TX_DONE]  = tx_clr_if.done;
        irq_set[`UFC_IRQ_RX_DONE]  = rx_clr_if.done;
        irq_clr = '0;
        if (bus_wr && hit_clr && wb_sel_i[0])
        begin
            irq_clr = wb_dat_i[`UFC_IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        q_nxt     = q_r;
        q_nxt.ack = bus_req;
        q_nxt.rts = rts_want;

        if (bus_req && !wb_we_i)
        begin
            if (hit_fcr)
            begin
                q_nxt.rdata = fcr_view;
            end
            else if (hit_stat)
            begin
                q_nxt.rdata = {{(32 - `UFC_IRQ_W){1'b0}}, q_r.stat};
            end
            else if (hit_en)
            begin
                q_nxt.rdata = {{(32 - `UFC_IRQ_W){1'b0}}, q_r.en};
            end
            else
            begin
                q_nxt.rdata = '0;
            end
        end

        if (wr_fcr && wb_sel_i[0])
        begin
            // RULE8 single buffer keeps the one-byte code
            if (HAS_FIFO)
            begin
                q_nxt.rx_code = wb_dat_i[`UFC_RX_THR_MSB:`UFC_RX_THR_LSB];
            end
        end

        if (wr_fcr && wb_sel_i[1])
        begin
            // RULE4 receiver disable bit
            q_nxt.rx_off = wb_dat_i[`UFC_BIT_RX_OFF];
        end

        if (wr_fcr && wb_sel_i[2])
        begin
            // RULE2 field absent without flow control
            if (HAS_FLOW)
            begin
                q_nxt.rts_code = wb_dat_i[`UFC_RTS_THR_MSB:`UFC_RTS_THR_LSB];
            end
        end

        // RULE11 start wins over the timer's done
        if (tx_clr_if.start)
        begin
            q_nxt.tx_clr = 1'b1;
        end
        else if (tx_clr_if.done)
        begin
            q_nxt.tx_clr = 1'b0;
        end

        if (rx_clr_if.start)
        begin
            q_nxt.rx_clr = 1'b1;
        end
        else if (rx_clr_if.done)
        begin
            q_nxt.rx_clr = 1'b0;
        end

        if (bus_wr && hit_en && wb_sel_i[0])
        begin
            q_nxt.en = wb_dat_i[`UFC_IRQ_W-1:0];
        end

        // RULE7 sticky flag, set beats clear
        q_nxt.stat   = (q_r.stat & ~irq_clr) | irq_set;
        q_nxt.irq    = |(q_nxt.stat & q_nxt.en);
        q_nxt.rx_int = q_nxt.stat[`UFC_IRQ_RX_AVAIL] && q_nxt.en[`UFC_IRQ_RX_AVAIL];
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_r          <= '0;
            q_r.rx_off   <= `UFC_RX_OFF_RESET;
            q_r.rx_code  <= `UFC_CODE_RESET;
            q_r.rts_code <= `UFC_CODE_RESET;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign wb_dat_o             = q_r.rdata;
    assign wb_ack_o             = q_r.ack;
    assign rts_o                = q_r.rts;
    assign receiver_off_o       = q_r.rx_off;
    assign tx_path_reset_o      = q_r.tx_clr;
    assign rx_path_reset_o      = q_r.rx_clr;
    assign rx_avail_flag_o      = q_r.stat[`UFC_IRQ_RX_AVAIL];
    assign rx_avail_interrupt_o = q_r.rx_int;
    assign irq_o                = q_r.irq;

endmodule // ufc_fifo_ctl

`default_nettype wire

// *** verification/ufc_rx_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Receive side of the channel, as seen from the control block.
// ----------------------------------------------------------------------------
module ufc_rx_peer #(
    parameter int CNT_W = 5
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             push_i,
    input  wire logic             rx_off_i,
    input  wire logic             flush_i,
    output logic      [CNT_W-1:0] count_o
);
    // The count only grows until reset or a receive path clear zeroes it; draining is left out to keep levels exact.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || flush_i)
            count_o <= '0;
        else if (push_i && !rx_off_i)
            count_o <= count_o + CNT_W'(4'h1);
    end
endmodule // ufc_rx_peer
`default_nettype wire

// *** verification/ufc_fifo_ctl_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Port checker of the FIFO control block.
// ----------------------------------------------------------------------------
module ufc_fifo_ctl_chk #(
    parameter int CNT_W = 5
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [7:0]       wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic [CNT_W-1:0] rx_count_i,
    input wire logic             auto_rts_en_i,
    input wire logic             rts_manual_i,
    input wire logic             rts_o,
    input wire logic             receiver_off_o,
    input wire logic             tx_path_reset_o,
    input wire logic             rx_path_reset_o,
    input wire logic             rx_avail_flag_o,
    input wire logic             rx_avail_interrupt_o,
    input wire logic             irq_o
);
    logic [3:0] rx_c_r;
    logic [3:0] rts_c_r;
    logic       take;
    logic       wctl;

    // Reserved codes act as one byte, as the block does.
    function automatic logic [CNT_W-1:0] lvl(input logic [3:0] c);
        case (c)
            4'h1:    lvl = CNT_W'(8'h04);
            4'h2:    lvl = CNT_W'(8'h08);
            4'h3:    lvl = CNT_W'(8'h0e);
            default: lvl = CNT_W'(8'h01);
        endcase
    endfunction

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wctl = take && wb_we_i && (wb_adr_i[7:2] == 6'h02);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_c_r  <= 4'h0;
            rts_c_r <= 4'h0;
        end
        else
        begin
            if (wctl && wb_sel_i[0])
                rx_c_r <= wb_dat_i[7:4];
            if (wctl && wb_sel_i[2])
                rts_c_r <= wb_dat_i[19:16];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_next_a:
        assert property (take |=> wb_ack_o) else $error("ack missing");
    ack_pulse_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    tx_clr_go_a:
        assert property (wctl && wb_sel_i[0] && wb_dat_i[2] |=> tx_path_reset_o)
        else $error("tx clear missing");
    rx_clr_go_a:
        assert property (wctl && wb_sel_i[0] && wb_dat_i[1] |=> rx_path_reset_o)
        else $error("rx clear missing");
    clr_len_a:
        assert property ($rose(rx_path_reset_o) |-> rx_path_reset_o[*3])
        else $error("clear too short");
    rx_avail_a:
        assert property (rx_count_i == lvl(rx_c_r) |=> rx_avail_flag_o)
        else $error("flag not set");
    rts_auto_a:
        assert property (auto_rts_en_i && rx_count_i >= lvl(rts_c_r) |=> !rts_o)
        else $error("rts not dropped");
    rts_manual_a:
        assert property (!auto_rts_en_i |=> rts_o == $past(rts_manual_i))
        else $error("manual rts wrong");
    rx_off_a:
        assert property (wctl && wb_sel_i[1] |=> receiver_off_o == $past(wb_dat_i[8]))
        else $error("receiver off wrong");
    irq_join_a:
        assert property (rx_avail_interrupt_o |-> irq_o) else $error("irq missing");
endmodule // ufc_fifo_ctl_chk

bind ufc_fifo_ctl ufc_fifo_ctl_chk #(.CNT_W(CNT_W)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_count_i(rx_count_i), .auto_rts_en_i(auto_rts_en_i),
    .rts_manual_i(rts_manual_i), .rts_o(rts_o), .receiver_off_o(receiver_off_o),
    .tx_path_reset_o(tx_path_reset_o), .rx_path_reset_o(rx_path_reset_o),
    .rx_avail_flag_o(rx_avail_flag_o), .rx_avail_interrupt_o(rx_avail_interrupt_o),
    .irq_o(irq_o)
);
`default_nettype wire

// *** verification/tb_uart_fifo_control.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Register level tests of the FIFO control block.
// ----------------------------------------------------------------------------
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module tb_uart_fifo_control;
    logic        clk_i, rst_i, cyc, stb, we, auto, man, push;
    logic        ack, rts, roff, txr, rxr, flag, rint, irq;
    logic [7:0]  adr;
    logic [7:0]  lv [5] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h01};
    logic [3:0]  sel, code;
    logic [31:0] dat, rd, dout;
    logic [4:0]  cnt;
    int          error_cnt, checks, i;

    ufc_fifo_ctl dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
        .wb_ack_o(ack), .rx_count_i(cnt), .auto_rts_en_i(auto), .rts_manual_i(man),
        .rts_o(rts), .receiver_off_o(roff), .tx_path_reset_o(txr),
        .rx_path_reset_o(rxr), .rx_avail_flag_o(flag),
        .rx_avail_interrupt_o(rint), .irq_o(irq)
    );
    ufc_rx_peer peer_u (
        .clk_i(clk_i), .rst_i(rst_i), .push_i(push), .rx_off_i(roff),
        .flush_i(rxr), .count_o(cnt)
    );

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'h1 && n < 20);
        if (n >= 20)
            error_cnt++;
        rd = dout;
        {cyc, stb, we} <= 3'h0;
    endtask

    // Wait k clock edges and then 1 ns so that edge updates have landed before sampling.
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic push_n(input int k);
        repeat (k)
        begin
            @(posedge clk_i);
            push <= 1'h1;
            @(posedge clk_i);
            push <= 1'h0;
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        results();
    end

    initial
    begin
        {rst_i, cyc, stb, we, auto, man, push} = 7'h40;
        {adr, sel, dat} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h0, 8'h08, 32'h0, 4'hf);
        `CHK(rd, 32'h00000101);
        `CHK(roff, 1'h1);
        wb(1'h1, 8'h08, 32'hfffffff9, 4'hf);
        wb(1'h0, 8'h08, 32'h0, 4'hf);
        `CHK(rd, 32'h000f01f1);
        `CHK({txr, rxr}, 2'h0);
        wb(1'h1, 8'h08, 32'h0, 4'h2);
        step(1);
        `CHK(roff, 1'h0);
        wb(1'h1, 8'h28, 32'h1, 4'h1);
        auto <= 1'h1;
        for (i = 0; i < 5; i++)
        begin
            code = 4'(i);
            wb(1'h1, 8'h08, {12'h0, code, 8'h0, code, 4'h2}, 4'h5);
            #1;
            `CHK(rxr, 1'h1);
            step(3);
            `CHK({rxr, cnt}, 6'h00);
            wb(1'h1, 8'h24, 32'hf, 4'h1);
            push_n(int'(lv[i]) - 1);
            step(3);
            `CHK({flag, rts}, 2'h1);
            push_n(1);
            step(3);
            `CHK({flag, rint, irq, rts}, 4'he);
        end
        wb(1'h1, 8'h28, 32'h0, 4'h1);
        step(1);
        `CHK({flag, irq}, 2'h2);
        wb(1'h1, 8'h08, 32'h2, 4'h1);
        step(4);
        wb(1'h1, 8'h24, 32'hf, 4'h1);
        wb(1'h0, 8'h20, 32'h0, 4'hf);
        `CHK(rd, 32'h0);
        wb(1'h1, 8'h28, 32'h4, 4'h1);
        wb(1'h1, 8'h08, 32'h4, 4'h1);
        #1;
        `CHK(txr, 1'h1);
        step(4);
        `CHK({txr, irq}, 2'h1);
        wb(1'h0, 8'h20, 32'h0, 4'hf);
        `CHK(rd, 32'h4);
        wb(1'h1, 8'h40, 32'hffffffff, 4'hf);
        wb(1'h0, 8'h40, 32'h0, 4'hf);
        `CHK(rd, 32'h0);
        wb(1'h0, 8'h24, 32'h0, 4'hf);
        `CHK(rd, 32'h0);
        @(posedge clk_i);
        {auto, man} <= 2'h1;
        step(2);
        `CHK(rts, 1'h1);
        @(posedge clk_i);
        man <= 1'h0;
        step(2);
        `CHK(rts, 1'h0);
        results();
    end
endmodule // tb_uart_fifo_control
`default_nettype wire
